// ---- pkg/pacq_pkg.sv ----
// pacq_pkg: constants and carrier types for the pipelined converter output side
// assumes a single 25 MHz system clock; the sampling clock arrives as a sampled input
package pacq_pkg;
    localparam int PACQ_WIDTH = 12;
    localparam int PACQ_LATENCY = 7;
    localparam int PACQ_SYNC_STAGES = 2;
    localparam int PACQ_BUF_DEPTH = 2;
    localparam logic [11:0] PACQ_OB_NEG_FS = 12'h000;
    localparam logic [11:0] PACQ_OB_POS_FS = 12'hfff;
    localparam logic [11:0] PACQ_MID = 12'h800;
    localparam logic [11:0] PACQ_WORD_RST = 12'h000;
    localparam logic [2:0] PACQ_FILL_RST = 3'h0;
    // four select levels, coded as a 2-bit level from the analog comparator
    typedef enum logic [1:0] {
        PACQ_SEL_GND = 2'h0,
        PACQ_SEL_THIRD = 2'h1,
        PACQ_SEL_TWO_THIRDS = 2'h2,
        PACQ_SEL_SUPPLY = 2'h3
    } pacq_sel_t;
    typedef struct packed {
        logic twos_comp;
        logic stabilizer_on;
    } pacq_mode_t;
    typedef struct packed {
        logic [11:0] word;
    } pacq_word_t;
endpackage

// ---- hw/pacq_buf2.sv ----
// pacq_buf2: two-entry valid/ready buffer for output words
// assumes producer and consumer on the same clock; read data come from a register
`timescale 1ns/1ns
module pacq_buf2
    import pacq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire pacq_word_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output pacq_word_t out_data
);
    pacq_word_t mem_q [PACQ_BUF_DEPTH];
    pacq_word_t mem_d [PACQ_BUF_DEPTH];
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    // a full buffer still takes a word when the head leaves in the same cycle, so a one-tick stall loses nothing
    assign in_ready = (cnt_q != 2'h2) || out_ready;
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // shift-register queue: entry 0 is always the head
    always_comb begin
        mem_d = mem_q;
        cnt_d = cnt_q;
        if (pop) begin
            mem_d[0] = mem_q[1];
        end
        if (push) begin
            mem_d[(pop ? cnt_q - 2'h1 : cnt_q) == 2'h0 ? 0 : 1] = in_data;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            cnt_d = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule

// ---- hw/pacq_out_if.sv ----
// pacq_out_if: digital output side of a 12-bit pipelined converter
// assumes the sampling clock and all pins come from outside; all but capture_ready are synchronised here;
// the sampling clock must be well below half of sys_clk so each edge is seen
`timescale 1ns/1ns
module pacq_out_if
    import pacq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sample_clk_pin,
    input wire logic [12:0] analog_level_pin,
    input wire logic [1:0] format_and_stabilizer_select,
    input wire logic sleep_request_pin,
    input wire logic capture_ready,
    output logic [11:0] sample_word_bus,
    output logic sample_strobe_out,
    output logic duty_cycle_stabilizer,
    output logic low_power_q,
    output logic words_valid
);
    // two-flop synchronisers for every outside input except capture_ready
    logic clk_s1_q, clk_s2_q, clk_prev_q;
    logic pd_s1_q, pd_s2_q;
    logic [1:0] sel_s1_q, sel_s2_q;
    logic [12:0] lvl_s1_q, lvl_s2_q;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_prev_q <= 1'b0;
            pd_s1_q <= 1'b1;
            pd_s2_q <= 1'b1;
            sel_s1_q <= 2'h0;
            sel_s2_q <= 2'h0;
            lvl_s1_q <= '0;
            lvl_s2_q <= '0;
        end else begin
            clk_s1_q <= sample_clk_pin;
            clk_s2_q <= clk_s1_q;
            clk_prev_q <= clk_s2_q;
            pd_s1_q <= sleep_request_pin;
            pd_s2_q <= pd_s1_q;
            sel_s1_q <= format_and_stabilizer_select;
            sel_s2_q <= sel_s1_q;
            lvl_s1_q <= analog_level_pin;
            lvl_s2_q <= lvl_s1_q;
        end
    end

    logic samp_tick;
    assign samp_tick = clk_s2_q && !clk_prev_q;

    function automatic pacq_mode_t decode_sel(input logic [1:0] lvl);
        pacq_mode_t m;
        m.twos_comp = (lvl == PACQ_SEL_SUPPLY) || (lvl == PACQ_SEL_TWO_THIRDS);
        m.stabilizer_on = (lvl == PACQ_SEL_THIRD) || (lvl == PACQ_SEL_TWO_THIRDS);
        return m;
    endfunction

    // clip 13-bit input to the 12-bit offset binary range
    // input is offset binary with one spare bit: msb set, bit 11 clear (above fff) saturates high; msb and bit 11 set (below 0) saturates low
    function automatic logic [11:0] clip_code(input logic [12:0] raw);
        logic [11:0] c;
        c = raw[11:0];
        if (raw[12]) begin
            c = raw[11] ? PACQ_OB_NEG_FS : PACQ_OB_POS_FS;
        end
        return c;
    endfunction

    pacq_mode_t mode;
    // one select input drives both choices
    assign mode = decode_sel(sel_s2_q);

    // pipeline of offset-binary codes plus a fill count
    // the output buffer is the last of the seven stages, so the shift chain holds one fewer
    logic [11:0] pipe_q [PACQ_LATENCY - 1];
    logic [11:0] pipe_d [PACQ_LATENCY - 1];
    logic [2:0] fill_q, fill_d;
    logic pd_prev_q, sel_changed;
    logic [1:0] sel_prev_q;
    assign sel_changed = (sel_prev_q != sel_s2_q);

    always_comb begin
        pipe_d = pipe_q;
        fill_d = fill_q;
        if (pd_s2_q || sel_changed) begin
            // pipeline contents are lost in power-down
            fill_d = PACQ_FILL_RST;
        end else if (samp_tick) begin
            // shift one stage per sampling edge
            pipe_d[0] = clip_code(lvl_s2_q);
            for (int i = 1; i < PACQ_LATENCY - 1; i++) begin
                pipe_d[i] = pipe_q[i - 1];
            end
            if (fill_q != 3'(PACQ_LATENCY - 1)) begin
                fill_d = fill_q + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < PACQ_LATENCY - 1; i++) begin
                pipe_q[i] <= PACQ_WORD_RST;
            end
            fill_q <= PACQ_FILL_RST;
            pd_prev_q <= 1'b1;
            sel_prev_q <= 2'h0;
        end else begin
            pipe_q <= pipe_d;
            fill_q <= fill_d;
            pd_prev_q <= pd_s2_q;
            sel_prev_q <= sel_s2_q;
        end
    end

    // format conversion, two's complement flips the msb
    pacq_word_t fmt_word;
    // msb flip maps 000/800/fff to 800/000/7ff
    assign fmt_word.word = pipe_q[PACQ_LATENCY - 2] ^ (mode.twos_comp ? PACQ_MID : 12'h000);

    // buffer absorbs a capture stall without dropping a word
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_take;
    pacq_word_t buf_out;
    // exactly one word per sampling edge once filled
    assign buf_in_valid = samp_tick && !pd_s2_q && (fill_q == 3'(PACQ_LATENCY - 1));
    // the head leaves only when it is put on the bus, never between sampling edges
    assign buf_take = samp_tick && !pd_s2_q && capture_ready;
    // stale words of the old format must not outlive a select change
    pacq_buf2 u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .flush(pd_s2_q || sel_changed),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(fmt_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_take),
        .out_data(buf_out)
    );

    // output stage: strobe low then high around each presented word
    logic [11:0] bus_d;
    logic strobe_d, dcs_d, lp_d, valid_d;
    always_comb begin
        bus_d = sample_word_bus;
        strobe_d = clk_s2_q;
        dcs_d = mode.stabilizer_on;
        lp_d = pd_s2_q;
        valid_d = words_valid;
        if (pd_s2_q) begin
            bus_d = PACQ_WORD_RST;
            valid_d = 1'b0;
        end else if (samp_tick) begin
            // a stalled or empty tick still strobes, so valid drops to mark the bus stale
            valid_d = 1'b0;
            if (buf_take && buf_out_valid) begin
                // twelve-bit word changes on the strobe's rising edge
                bus_d = buf_out.word;
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sample_word_bus <= PACQ_WORD_RST;
            sample_strobe_out <= 1'b0;
            duty_cycle_stabilizer <= 1'b0;
            low_power_q <= 1'b1;
            words_valid <= 1'b0;
        end else begin
            sample_word_bus <= bus_d;
            sample_strobe_out <= strobe_d;
            duty_cycle_stabilizer <= dcs_d;
            low_power_q <= lp_d;
            words_valid <= valid_d;
        end
    end

    // assertions
    property p_lowpower;
        @(posedge sys_clk) disable iff (!nrst) pd_s2_q |=> low_power_q;
    endproperty
    a_lowpower: assert property (p_lowpower) else $error("power-down not reflected");

    property p_pd_flush;
        @(posedge sys_clk) disable iff (!nrst) pd_s2_q |=> (fill_q == 3'h0) && !words_valid;
    endproperty
    a_pd_flush: assert property (p_pd_flush) else $error("pipeline kept in power-down");

    property p_fmt;
        @(posedge sys_clk) disable iff (!nrst)
            fmt_word.word[10:0] == pipe_q[PACQ_LATENCY - 2][10:0];
    endproperty
    a_fmt: assert property (p_fmt) else $error("format touched low bits");

    property p_tc_msb;
        @(posedge sys_clk) disable iff (!nrst)
            mode.twos_comp |-> fmt_word.word[11] != pipe_q[PACQ_LATENCY - 2][11];
    endproperty
    a_tc_msb: assert property (p_tc_msb) else $error("msb not inverted");

    property p_sel;
        @(posedge sys_clk) disable iff (!nrst)
            (sel_s2_q == PACQ_SEL_TWO_THIRDS) |-> mode.twos_comp && mode.stabilizer_on;
    endproperty
    a_sel: assert property (p_sel) else $error("select decode wrong");

    property p_dcs;
        @(posedge sys_clk) disable iff (!nrst) ##1 duty_cycle_stabilizer == $past(mode.stabilizer_on);
    endproperty
    a_dcs: assert property (p_dcs) else $error("stabilizer output stale");

    property p_strobe;
        @(posedge sys_clk) disable iff (!nrst) samp_tick |=> sample_strobe_out;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe missed edge");

    property p_clip;
        @(posedge sys_clk) disable iff (!nrst)
            (samp_tick && !pd_s2_q && !sel_changed && lvl_s2_q[12] && !lvl_s2_q[11])
            |=> pipe_q[0] == PACQ_OB_POS_FS;
    endproperty
    a_clip: assert property (p_clip) else $error("overrange wrapped");

    property p_one_word;
        @(posedge sys_clk) disable iff (!nrst) !samp_tick |=> $stable(sample_word_bus) || pd_prev_q;
    endproperty
    a_one_word: assert property (p_one_word) else $error("bus changed off edge");

    property p_fill;
        @(posedge sys_clk) disable iff (!nrst) buf_in_valid |-> fill_q == 3'(PACQ_LATENCY - 1);
    endproperty
    a_fill: assert property (p_fill) else $error("word before latency");

    property p_stale;
        @(posedge sys_clk) disable iff (!nrst) (samp_tick && !(buf_take && buf_out_valid)) |=> !words_valid;
    endproperty
    a_stale: assert property (p_stale) else $error("stale word marked valid");

    c_word: cover property (@(posedge sys_clk) disable iff (!nrst) samp_tick && buf_out_valid);
    c_pd: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(pd_s2_q));
    c_stall: cover property (@(posedge sys_clk) disable iff (!nrst) !buf_in_ready);
endmodule

// ---- testbench/pacq_cap_model.sv ----
// capture model: far-side logic that latches converter words
// assumes strobe, bus and valid are sys_clk registers of the converter block
`timescale 1ns/1ns
module pacq_cap_model
    import pacq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [11:0] sample_word_bus,
    input wire logic sample_strobe_out,
    input wire logic words_valid,
    input wire logic hold_off,
    output logic capture_ready,
    output logic got_q,
    output logic [11:0] word_q
);
    logic strobe_q;
    logic [1:0] rest_q;
    always_ff @(posedge sys_clk) begin
        strobe_q <= sample_strobe_out;
        got_q <= nrst && sample_strobe_out && !strobe_q && words_valid;
        if (sample_strobe_out && !strobe_q) begin
            word_q <= sample_word_bus;
        end
        // short stall after each capture; the bus stands then, so no word may be lost
        if (!nrst) begin
            rest_q <= 2'h0;
        end else if (sample_strobe_out && !strobe_q) begin
            rest_q <= 2'h3;
        end else if (rest_q != 2'h0) begin
            rest_q <= rest_q - 2'h1;
        end
        capture_ready <= !hold_off && rest_q == 2'h0;
    end
endmodule

// ---- testbench/tb_pacq_out_if.sv ----
// tb_pacq_out_if: random and corner samples through the converter output side
// assumes the capture model as far side; sampling clock is 8 sys_clk periods
`timescale 1ns/1ns
module tb_pacq_out_if;
    import pacq_pkg::*;
    logic sys_clk, nrst, sample_clk_pin, sleep_request_pin, hold_off, capture_ready, got_q;
    logic [12:0] analog_level_pin, lvl;
    logic [1:0] format_and_stabilizer_select;
    logic [11:0] sample_word_bus, word_q;
    logic sample_strobe_out, duty_cycle_stabilizer, low_power_q, words_valid, prev_s;
    logic [11:0] exp_q[$];
    logic [12:0] corner_q[$];
    int errors, checked, cycles, rises, seed, phase, resync, run, idx, lat_on;
    pacq_out_if pacq_out_if_i(.sys_clk(sys_clk), .nrst(nrst), .sample_clk_pin(sample_clk_pin),
        .analog_level_pin(analog_level_pin), .format_and_stabilizer_select(format_and_stabilizer_select),
        .sleep_request_pin(sleep_request_pin), .capture_ready(capture_ready), .sample_word_bus(sample_word_bus),
        .sample_strobe_out(sample_strobe_out), .duty_cycle_stabilizer(duty_cycle_stabilizer),
        .low_power_q(low_power_q), .words_valid(words_valid));
    pacq_cap_model pacq_cap_model_i(.sys_clk(sys_clk), .nrst(nrst), .sample_word_bus(sample_word_bus),
        .sample_strobe_out(sample_strobe_out), .words_valid(words_valid), .hold_off(hold_off),
        .capture_ready(capture_ready), .got_q(got_q), .word_q(word_q));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // offset binary with clipping; two's complement only flips the msb
    function automatic logic [11:0] conv(input logic [12:0] a, input logic [1:0] s);
        logic [11:0] w;
        w = a[12] ? (a[11] ? PACQ_OB_NEG_FS : PACQ_OB_POS_FS) : a[11:0];
        return s[1] ? {~w[11], w[10:0]} : w;
    endfunction
    // sampling clock, analog level and in-order scoreboard share one process
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
        if (sample_strobe_out && !prev_s) rises++;
        prev_s = sample_strobe_out;
        if (got_q) begin
            idx = -1;
            foreach (exp_q[i]) if (idx < 0 && exp_q[i] === word_q) idx = i;
            // skip words until the refilled pipeline lines up
            if (resync && idx >= 0) begin
                exp_q = exp_q[idx:$];
                resync = 0;
            end
            if (!resync) begin
                chk(word_q, exp_q.size() ? exp_q.pop_front() : 12'h000);
                run++;
                if (run > 2 && lat_on) chk(12'(exp_q.size() == PACQ_LATENCY + 1), 12'h001);
            end
        end
        phase = (phase + 1) % 8;
        sample_clk_pin <= phase < 4;
        if (phase == 4) begin
            lvl = corner_q.size() ? corner_q.pop_front() : 13'($random(seed));
            analog_level_pin <= lvl;
            exp_q.push_back(conv(lvl, format_and_stabilizer_select));
        end
    end
    initial begin
        seed = 32'h894f;
        nrst = 1'b0;
        sample_clk_pin = 1'b0;
        analog_level_pin = 13'h0800;
        format_and_stabilizer_select = 2'h0;
        sleep_request_pin = 1'b0;
        hold_off = 1'b0;
        lat_on = 1;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            format_and_stabilizer_select <= 2'(s);
            // words still in flight belong to the old stream; resync only once the flush has passed
            repeat (8) @(posedge sys_clk);
            resync = 1;
            run = 0;
            repeat (56) @(posedge sys_clk);
            corner_q = '{13'h0000, 13'h0400, 13'h0800, 13'h0c00, 13'h0fff, 13'h1800, 13'h1000};
            @(negedge sys_clk) rises = 0;
            repeat (176) @(posedge sys_clk);
            #1;
            chk(12'(rises), 12'h016);
            chk(12'(duty_cycle_stabilizer), 12'(s[0] ^ s[1]));
            chk(12'(run >= 20), 12'h001);
            $display("select level %0d done", s);
        end
        // receiver stall over exactly one sampling edge: the buffer covers it, no word lost, order kept
        lat_on = 0;
        run = 0;
        hold_off <= 1'b1;
        repeat (8) @(posedge sys_clk);
        hold_off <= 1'b0;
        repeat (312) @(posedge sys_clk);
        chk(12'(run >= 36), 12'h001);
        $display("stall done");
        sleep_request_pin <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk(12'(low_power_q), 12'h001);
        chk(12'(words_valid), 12'h000);
        sleep_request_pin <= 1'b0;
        resync = 1;
        run = 0;
        lat_on = 1;
        repeat (240) @(posedge sys_clk);
        chk(12'(low_power_q), 12'h000);
        chk(12'(run >= 20), 12'h001);
        $display("sleep done");
        give_verdict();
    end
endmodule
